// *** src/pin_ctrl_defs.vh ***
`ifndef PIN_CTRL_DEFS_VH
`define PIN_CTRL_DEFS_VH
// Register byte addresses
`define REG_PORTA_DATA   8'h00
`define REG_PORTB_DATA   8'h04
`define REG_PORTC_DATA   8'h08
`define REG_PORTA_DIR    8'h0C
`define REG_PORTB_DIR    8'h10
`define REG_PORTC_DIR    8'h14
`define REG_PULLUP_A     8'h18
`define REG_PULLUP_B     8'h1C
`define REG_SLOW_EDGE    8'h20
`define REG_FUNC_EN      8'h24
`define REG_IRQ_STATUS   8'h28
`define REG_IRQ_MASK     8'h2C
// Function enable fields
`define FN_SECOND_EXTERNAL_INTERRUPT_BIT      0
`define FN_CAPTURE_BIT   1
`define FN_ANALOG_BIT    2
// Slow edge fields
`define SLOW_B_LSB       0
`define SLOW_A6_BIT      5
`define SLOW_A7_BIT      6
// Status fields
`define ST_IRQ_BIT       0
`define ST_SECOND_EXTERNAL_INTERRUPT_BIT      1
`define ST_CAPTURE_BIT   2
// Reset values
`define RESET_DIR        8'h00
`define RESET_ZERO       8'h00
// Timing
`define OSC_DIV_OP       2
`define OSC_DIV_SERIAL   4
`define START_LONG       4064
`define START_SHORT      128
`define LOW_RESET_CYCLES 4
`endif

// *** src/pin_sync.v ***
`timescale 1ns/1ns
module pin_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_reset_n,
	// Data
	input  wire [WIDTH-1:0] i_async,
	output reg  [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] stage;

	// First stage is read only by the second
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage  <= {WIDTH{1'b0}};
			o_sync <= {WIDTH{1'b0}};
		end else begin
			stage  <= i_async;
			o_sync <= stage;
		end
	end
endmodule

// *** src/port_pin_function_control.v ***
// What this block does
// - Operating clock enable ticks at oscillator rate divided by two.
// - Serial bus clock derived from oscillator divided by four.
// - All port lines are inputs after power-on and every reset.
// - Interrupt senses falling edges, optionally also sustained low level.
// - Option ORs port A lines 0-3 into interrupt with same sensitivity.
// - Port A line 4 is second interrupt input when enabled.
// - Port B line 0 routes to capture input when enabled.
// - Analog enable makes port C 0-3 inputs, 4 high, 5 low reference.
// - Analog enable lets port B lines 3 and 4 be channels four, five.
// - Low-voltage reset drives the reset pin low as an output.
// - External low on reset pin returns block to start-up state.
// - Operation held off 4064 or 128 cycles after oscillator start.
// - Software enables pull-ups on port A 0-4 and port B lines.
// - Software slow falling-edge control on port B and port A 6, 7.
`timescale 1ns/1ns
`include "pin_ctrl_defs.vh"
module port_pin_function_control #(
	parameter LEVEL_SENSE     = 1'b0,
	parameter PORTA_IRQ_EN    = 1'b0,
	parameter SHORT_START     = 1'b0,
	parameter START_LONG_CYC  = `START_LONG
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_reset_n,
	// Wishbone slave
	input  wire        i_wb_cyc,
	input  wire        i_wb_stb,
	input  wire        i_wb_we,
	input  wire [7:0]  i_wb_adr,
	input  wire [3:0]  i_wb_sel,
	input  wire [31:0] i_wb_dat,
	output reg  [31:0] o_wb_dat,
	output reg         o_wb_ack,
	output reg         o_irq,
	// Pins
	input  wire [7:0]  i_port_a_lines,
	output reg  [7:0]  o_port_a_lines,
	output reg  [7:0]  o_port_a_oe,
	output reg  [7:0]  o_port_a_pullup,
	input  wire [4:0]  i_port_b_lines,
	output reg  [4:0]  o_port_b_lines,
	output reg  [4:0]  o_port_b_oe,
	output reg  [4:0]  o_port_b_pullup,
	output reg  [6:0]  o_slow_edge,
	input  wire [5:0]  i_port_c_lines,
	output reg  [5:0]  o_port_c_lines,
	output reg  [5:0]  o_port_c_oe,
	input  wire        i_irq_pin_n,
	input  wire        i_reset_pin_n,
	input  wire        i_low_voltage_reset,
	input  wire        i_osc_stable,
	output reg         o_reset_pin_n,
	output reg         o_reset_pin_oe,
	// Function outputs
	output reg         o_op_clk_en,
	output reg         o_serial_clk,
	output reg         o_run,
	output reg         o_capture_input,
	output reg         o_analog_en,
	output reg         o_analog_ref_sel,
	output reg  [5:0]  o_analog_channels
);
	// Counts are cut to their counter widths on purpose
	localparam [31:0] START_FULL = SHORT_START ? `START_SHORT : START_LONG_CYC;
	localparam [31:0] LOW_FULL   = `LOW_RESET_CYCLES;
	localparam [11:0] START_CYC  = START_FULL[11:0];
	localparam [2:0]  LOW_CYC    = LOW_FULL[2:0];

	reg  [1:0]  rst_sync;
	wire        rst_n = rst_sync[1];
	wire [7:0]  pa_s;
	wire [4:0]  pb_s;
	wire [5:0]  pc_s;
	wire [2:0]  ctl_s;
	reg  [7:0]  pa_out, pa_dir, pa_pu, pc_out;
	reg  [4:0]  pb_out, pb_dir, pb_pu;
	reg  [5:0]  pc_dir;
	reg  [6:0]  slow;
	reg  [2:0]  func_en;
	reg  [2:0]  status, mask;
	reg  [2:0]  next_status;
	reg  [31:0] next_rd;
	reg         irq_prev, second_external_interrupt_prev, cap_prev;
	reg  [1:0]  div_cnt;
	reg  [11:0] start_cnt;
	reg  [2:0]  lvr_cnt;
	reg  [1:0]  sync_fill;
	wire        settled = (sync_fill == 2'd3);
	wire        irq_line, irq_hit, second_external_interrupt_hit, cap_hit;
	wire        bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire        wr = bus_req && i_wb_we && i_wb_sel[0];
	wire        rd_status = bus_req && !i_wb_we && (i_wb_adr == `REG_IRQ_STATUS);

	// External reset pin joins the system reset before the release stages
	wire        any_reset_n = i_reset_n && i_reset_pin_n;
	always @(posedge i_clk or negedge any_reset_n) begin
		if (!any_reset_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	pin_sync #(.WIDTH(8)) sync_a (.i_clk(i_clk), .i_reset_n(rst_n), .i_async(i_port_a_lines), .o_sync(pa_s));
	pin_sync #(.WIDTH(5)) sync_b (.i_clk(i_clk), .i_reset_n(rst_n), .i_async(i_port_b_lines), .o_sync(pb_s));
	pin_sync #(.WIDTH(6)) sync_c (.i_clk(i_clk), .i_reset_n(rst_n), .i_async(i_port_c_lines), .o_sync(pc_s));
	pin_sync #(.WIDTH(3)) sync_ctl (
		.i_clk(i_clk),
		.i_reset_n(rst_n),
		.i_async({i_osc_stable, i_low_voltage_reset, i_irq_pin_n}),
		.o_sync(ctl_s)
	);

	// Interrupt line is low-active; port A 0-3 ORed in as extra sources
	assign irq_line = ctl_s[0] & ~(PORTA_IRQ_EN & ~(&pa_s[3:0]));
	// Falling edge always; sustained low also if the level option is built
	assign irq_hit  = settled & ((irq_prev & ~irq_line) | (LEVEL_SENSE & ~irq_line));
	assign second_external_interrupt_hit = settled & func_en[`FN_SECOND_EXTERNAL_INTERRUPT_BIT] & second_external_interrupt_prev & ~pa_s[4];
	assign cap_hit  = settled & func_en[`FN_CAPTURE_BIT] & (cap_prev ^ pb_s[0]);

	// Synchronisers show reset zeros, not the idle-high pins, for the first edges after reset;
	// edge and level detectors ignore them until the previous-value registers hold real levels
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_fill <= 2'd0;
		end else if (sync_fill != 2'd3) begin
			sync_fill <= sync_fill + 2'd1;
		end
	end

	always @* begin
		next_status = status;
		if (rd_status) begin
			next_status = 3'b000;
		end
		// Set beats the read-clear in the same cycle
		next_status[`ST_IRQ_BIT]     = next_status[`ST_IRQ_BIT] | irq_hit;
		next_status[`ST_SECOND_EXTERNAL_INTERRUPT_BIT]    = next_status[`ST_SECOND_EXTERNAL_INTERRUPT_BIT] | second_external_interrupt_hit;
		next_status[`ST_CAPTURE_BIT] = next_status[`ST_CAPTURE_BIT] | cap_hit;
	end

	// Unmapped addresses and unused upper bits read as zero
	always @* begin
		next_rd = 32'h0000_0000;
		if (i_wb_adr == `REG_PORTA_DATA) begin
			next_rd[7:0] = (pa_out & pa_dir) | (pa_s & ~pa_dir);
		end else if (i_wb_adr == `REG_PORTB_DATA) begin
			next_rd[4:0] = (pb_out & pb_dir) | (pb_s & ~pb_dir);
		end else if (i_wb_adr == `REG_PORTC_DATA) begin
			next_rd[5:0] = (pc_out[5:0] & pc_dir) | (pc_s & ~pc_dir);
		end else if (i_wb_adr == `REG_PORTA_DIR) begin
			next_rd[7:0] = pa_dir;
		end else if (i_wb_adr == `REG_PORTB_DIR) begin
			next_rd[4:0] = pb_dir;
		end else if (i_wb_adr == `REG_PORTC_DIR) begin
			next_rd[5:0] = pc_dir;
		end else if (i_wb_adr == `REG_PULLUP_A) begin
			next_rd[7:0] = pa_pu;
		end else if (i_wb_adr == `REG_PULLUP_B) begin
			next_rd[4:0] = pb_pu;
		end else if (i_wb_adr == `REG_SLOW_EDGE) begin
			next_rd[6:0] = slow;
		end else if (i_wb_adr == `REG_FUNC_EN) begin
			next_rd[2:0] = func_en;
		end else if (i_wb_adr == `REG_IRQ_STATUS) begin
			next_rd[2:0] = status;
		end else if (i_wb_adr == `REG_IRQ_MASK) begin
			next_rd[2:0] = mask;
		end
	end

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pa_out    <= `RESET_ZERO;
			pb_out    <= 5'h00;
			pc_out    <= `RESET_ZERO;
			pa_dir    <= `RESET_DIR;
			pb_dir    <= 5'h00;
			pc_dir    <= 6'h00;
			pa_pu     <= `RESET_ZERO;
			pb_pu     <= 5'h00;
			slow      <= 7'h00;
			func_en   <= 3'h0;
			mask      <= 3'h0;
			status    <= 3'h0;
			irq_prev  <= 1'b1;
			second_external_interrupt_prev <= 1'b1;
			cap_prev  <= 1'b0;
			o_wb_ack  <= 1'b0;
			o_wb_dat  <= 32'h0000_0000;
			o_irq     <= 1'b0;
		end else begin
			irq_prev  <= irq_line;
			second_external_interrupt_prev <= pa_s[4];
			cap_prev  <= pb_s[0];
			status    <= next_status;
			o_irq     <= |(next_status & mask);
			o_wb_ack  <= bus_req;
			o_wb_dat  <= bus_req ? next_rd : 32'h0000_0000;
			if (wr) begin
				if (i_wb_adr == `REG_PORTA_DATA) begin
					pa_out <= i_wb_dat[7:0];
				end else if (i_wb_adr == `REG_PORTB_DATA) begin
					pb_out <= i_wb_dat[4:0];
				end else if (i_wb_adr == `REG_PORTC_DATA) begin
					pc_out <= {2'b00, i_wb_dat[5:0]};
				end else if (i_wb_adr == `REG_PORTA_DIR) begin
					pa_dir <= i_wb_dat[7:0];
				end else if (i_wb_adr == `REG_PORTB_DIR) begin
					pb_dir <= i_wb_dat[4:0];
				end else if (i_wb_adr == `REG_PORTC_DIR) begin
					pc_dir <= i_wb_dat[5:0];
				end else if (i_wb_adr == `REG_PULLUP_A) begin
					pa_pu <= {3'b000, i_wb_dat[4:0]};
				end else if (i_wb_adr == `REG_PULLUP_B) begin
					pb_pu <= i_wb_dat[4:0];
				end else if (i_wb_adr == `REG_SLOW_EDGE) begin
					slow <= i_wb_dat[6:0];
				end else if (i_wb_adr == `REG_FUNC_EN) begin
					func_en <= i_wb_dat[2:0];
				end else if (i_wb_adr == `REG_IRQ_MASK) begin
					mask <= i_wb_dat[2:0];
				end
			end
		end
	end

	// Pin drivers; alternate functions take the pin away from the output path
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_port_a_lines   <= 8'h00;
			o_port_a_oe      <= 8'h00;
			o_port_a_pullup  <= 8'h00;
			o_port_b_lines   <= 5'h00;
			o_port_b_oe      <= 5'h00;
			o_port_b_pullup  <= 5'h00;
			o_port_c_lines   <= 6'h00;
			o_port_c_oe      <= 6'h00;
			o_slow_edge      <= 7'h00;
			o_capture_input  <= 1'b0;
			o_analog_en      <= 1'b0;
			o_analog_ref_sel <= 1'b0;
			o_analog_channels <= 6'h00;
		end else begin
			o_port_a_lines  <= pa_out;
			o_port_a_oe     <= pa_dir & {3'b111, ~func_en[`FN_SECOND_EXTERNAL_INTERRUPT_BIT], 4'hF};
			o_port_a_pullup <= pa_pu & ~pa_dir;
			o_port_b_lines  <= pb_out;
			o_port_b_oe     <= pb_dir & {~func_en[`FN_ANALOG_BIT], ~func_en[`FN_ANALOG_BIT], 2'b11,
				~func_en[`FN_CAPTURE_BIT]};
			o_port_b_pullup <= pb_pu & ~pb_dir;
			o_port_c_lines  <= pc_out[5:0];
			o_port_c_oe     <= func_en[`FN_ANALOG_BIT] ? 6'h00 : pc_dir;
			// Slow falling edge only matters while the line drives
			o_slow_edge     <= slow & {pa_dir[7], pa_dir[6], pb_dir};
			o_capture_input <= func_en[`FN_CAPTURE_BIT] & pb_s[0];
			o_analog_en     <= func_en[`FN_ANALOG_BIT];
			o_analog_ref_sel <= func_en[`FN_ANALOG_BIT];
			o_analog_channels <= func_en[`FN_ANALOG_BIT] ? {pb_s[4], pb_s[3], pc_s[3:0]} : 6'h00;
		end
	end

	// Clock dividers from the oscillator-rate clock
	// Bit 0 toggles every edge, so the enable marks every other oscillator cycle
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt      <= 2'd0;
			o_op_clk_en  <= 1'b0;
			o_serial_clk <= 1'b0;
		end else begin
			div_cnt      <= div_cnt + 2'd1;
			o_op_clk_en  <= (div_cnt[0] == 1'b1);
			o_serial_clk <= (div_cnt == 2'd1) ? 1'b1 :
				(div_cnt == 2'd3) ? 1'b0 : o_serial_clk;
		end
	end

	// Start-up hold-off counted once the oscillator reports stable
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_cnt <= 12'd0;
			o_run     <= 1'b0;
		end else if (ctl_s[2] && !o_run) begin
			start_cnt <= start_cnt + 12'd1;
			o_run     <= (start_cnt == START_CYC - 12'd1);
		end
	end

	// Low-voltage reset drives the pin; stretched so the pulse is seen outside
	// Only the raw reset clears this block, since the pin it drives resets everything else
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lvr_cnt        <= 3'd0;
			o_reset_pin_n  <= 1'b1;
			o_reset_pin_oe <= 1'b0;
		end else begin
			if (ctl_s[1]) begin
				lvr_cnt <= LOW_CYC;
			end else if (lvr_cnt != 3'd0) begin
				lvr_cnt <= lvr_cnt - 3'd1;
			end
			o_reset_pin_n  <= 1'b0;
			o_reset_pin_oe <= ctl_s[1] || (lvr_cnt != 3'd0);
		end
	end
endmodule

// *** tb/pin_partner.sv ***
`timescale 1ns/1ns
module pin_partner #(
	parameter int W = 8
) (
	// Design side
	input  wire logic [W-1:0] i_out,
	input  wire logic [W-1:0] i_oe,
	// Outside world
	input  wire logic [W-1:0] i_ext,
	output wire logic [W-1:0] o_level
);
	// The outside world never fights a driven line; released lines take its level
	assign o_level = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// *** tb/port_pin_function_control_checker.sv ***
`timescale 1ns/1ns
module port_pin_function_control_checker (
	// Clock and resets
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic       i_reset_pin_n,
	input wire logic       i_low_voltage_reset,
	// Watched outputs
	input wire logic       o_op_clk_en,
	input wire logic       o_serial_clk,
	input wire logic       o_run,
	input wire logic [7:0] o_port_a_oe,
	input wire logic [4:0] o_port_b_oe,
	input wire logic [5:0] o_port_c_oe,
	input wire logic [7:0] o_port_a_pullup,
	input wire logic [4:0] o_port_b_pullup,
	input wire logic [6:0] o_slow_edge,
	input wire logic       o_reset_pin_n,
	input wire logic       o_reset_pin_oe
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n || !i_reset_pin_n);
	chk_op_clk_div: assert property ($fell(o_op_clk_en) |=> o_op_clk_en)
		else $error("operating clock enable not every second cycle");
	chk_serial_div: assert property ($rose(o_serial_clk) |-> ##1 o_serial_clk ##1 !o_serial_clk)
		else $error("serial clock high phase not two cycles");
	chk_dir_reset: assert property (disable iff (1'b0) !i_reset_n |=> {o_port_a_oe, o_port_b_oe, o_port_c_oe} == 19'h0)
		else $error("port line driven during reset");
	chk_lvr_drive: assert property (disable iff (!i_reset_n) $rose(i_low_voltage_reset) |-> ##[0:3] o_reset_pin_oe)
		else $error("reset pin not driven on low voltage");
	chk_lvr_level: assert property (disable iff (!i_reset_n) o_reset_pin_oe |-> !o_reset_pin_n)
		else $error("reset pin driven high");
	chk_run_hold: assert property (o_run |=> o_run)
		else $error("run dropped without reset");
	chk_pull_a_top: assert property (o_port_a_pullup[7:5] == 3'h0)
		else $error("pull-up on port A line above four");
	chk_pull_b_in: assert property ($stable(o_port_b_oe) |-> (o_port_b_pullup & o_port_b_oe) == 5'h00)
		else $error("pull-up on driven port B line");
	chk_slow_out: assert property ($stable(o_port_b_oe) |-> (o_slow_edge[4:0] & ~o_port_b_oe) == 5'h00)
		else $error("slow edge on undriven port B line");
endmodule
bind port_pin_function_control port_pin_function_control_checker i_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_reset_pin_n(i_reset_pin_n), .i_low_voltage_reset(i_low_voltage_reset), .o_op_clk_en(o_op_clk_en),
	.o_serial_clk(o_serial_clk), .o_run(o_run), .o_port_a_oe(o_port_a_oe), .o_port_b_oe(o_port_b_oe),
	.o_port_c_oe(o_port_c_oe), .o_port_a_pullup(o_port_a_pullup), .o_port_b_pullup(o_port_b_pullup),
	.o_slow_edge(o_slow_edge), .o_reset_pin_n(o_reset_pin_n), .o_reset_pin_oe(o_reset_pin_oe));

// *** tb/test_port_pin_function_control.sv ***
`timescale 1ns/1ns
module test_port_pin_function_control;
	logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, irq_n = 1, ext_rst_n = 1, low_voltage_reset = 0, osc = 0;
	logic [7:0]  adr = 8'h00, a_ext = 8'hFF, a_out, a_oe, a_pu;
	logic [3:0]  sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [4:0]  b_ext = 5'h1F, b_out, b_oe, b_pu;
	logic [5:0]  c_ext = 6'h00, c_out, c_oe, chans;
	logic [6:0]  slow;
	logic [19:0] lvl;
	logic        ack, irq, rp_n, rp_oe, opc, sclk, run, capt, an_en, an_ref;
	int          num_errors = 0, check_count = 0, r;
	int          dm[3] = '{255, 31, 63};
	// One partner for every pin: port A, port B, port C, then the reset pin
	pin_partner #(.W(20)) i_pins (.i_out({a_out, b_out, c_out, rp_n}), .i_oe({a_oe, b_oe, c_oe, rp_oe}),
		.i_ext({a_ext, b_ext, c_ext, ext_rst_n}), .o_level(lvl));
	// Short start-up count keeps the run brief
	port_pin_function_control #(.LEVEL_SENSE(1'b1), .PORTA_IRQ_EN(1'b1), .START_LONG_CYC(16)) i_dut (
		.i_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq),
		.i_port_a_lines(lvl[19:12]), .o_port_a_lines(a_out), .o_port_a_oe(a_oe), .o_port_a_pullup(a_pu),
		.i_port_b_lines(lvl[11:7]), .o_port_b_lines(b_out), .o_port_b_oe(b_oe), .o_port_b_pullup(b_pu),
		.o_slow_edge(slow), .i_port_c_lines(lvl[6:1]), .o_port_c_lines(c_out), .o_port_c_oe(c_oe),
		.i_irq_pin_n(irq_n), .i_reset_pin_n(lvl[0]), .i_low_voltage_reset(low_voltage_reset), .i_osc_stable(osc),
		.o_reset_pin_n(rp_n), .o_reset_pin_oe(rp_oe), .o_op_clk_en(opc), .o_serial_clk(sclk), .o_run(run),
		.o_capture_input(capt), .o_analog_en(an_en), .o_analog_ref_sel(an_ref), .o_analog_channels(chans));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) num_errors++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic st(input logic [31:0] e);
		wb(1'b0, 8'h28, 32'h0);
		chk("status", q, e);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Oscillator input driven as an external clock
	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		num_errors++;
		results();
	end
	initial begin
		r = $urandom(32'h2b2295ce);
		tick(12);
		rst_n <= 1'b1;
		osc <= 1'b1;
		tick(12);
		chk("run_early", run, 0);
		tick(12);
		chk("run_late", run, 1);
		chk("oe_reset", {a_oe, b_oe, c_oe}, 0);
		for (int i = 0; i < 3; i++) begin
			wb(1'b0, 8'(12 + 4 * i), 32'h0);
			chk("dir_reset", q, 0);
			r = $urandom;
			wb(1'b1, 8'(12 + 4 * i), r);
			wb(1'b0, 8'(12 + 4 * i), 32'h0);
			chk("dir_rw", q, r & dm[i]);
		end
		wb(1'b1, 8'h0C, 32'hC0);
		wb(1'b1, 8'h10, 32'h06);
		wb(1'b1, 8'h14, 32'h00);
		sel <= 4'h0;
		wb(1'b1, 8'h0C, 32'hFF);
		sel <= 4'hF;
		wb(1'b0, 8'h0C, 32'h0);
		chk("sel_gate", q, 32'hC0);
		wb(1'b0, 8'h30, 32'h0);
		chk("unmapped", q, 0);
		wb(1'b1, 8'h18, 32'hFF);
		wb(1'b1, 8'h1C, 32'h1F);
		wb(1'b1, 8'h20, 32'h7F);
		tick(2);
		chk("pull_a", a_pu, 8'h1F);
		chk("pull_b", b_pu, 5'h19);
		chk("slow", slow, 7'h66);
		// Random directions above may have driven port A 0-3 low; clear that status first
		wb(1'b0, 8'h28, 32'h0);
		wb(1'b1, 8'h24, 32'h7);
		for (int i = 0; i < 4; i++) begin
			b_ext <= 5'($urandom);
			c_ext <= 6'($urandom);
			tick(5);
			chk("capture", capt, b_ext[0]);
			chk("an_en", {an_en, an_ref}, 2'b11);
			chk("chans", chans, {b_ext[4:3], c_ext[3:0]});
		end
		// A sure low-high pair on the capture line, whatever the random draws were
		b_ext <= 5'h1E;
		tick(6);
		b_ext <= 5'h1F;
		tick(6);
		wb(1'b1, 8'h2C, 32'h0);
		st(32'h4);
		irq_n <= 1'b0;
		tick(6);
		chk("irq_masked", irq, 0);
		wb(1'b1, 8'h2C, 32'h7);
		tick(2);
		chk("irq_on", irq, 1);
		st(32'h1);
		tick(2);
		st(32'h1);
		irq_n <= 1'b1;
		tick(6);
		wb(1'b0, 8'h28, 32'h0);
		st(32'h0);
		chk("irq_off", irq, 0);
		a_ext <= 8'hFE;
		tick(6);
		st(32'h1);
		a_ext <= 8'hFF;
		tick(6);
		wb(1'b0, 8'h28, 32'h0);
		a_ext <= 8'hEF;
		tick(6);
		st(32'h2);
		ext_rst_n <= 1'b0;
		tick(2);
		ext_rst_n <= 1'b1;
		tick(3);
		chk("oe_pin_reset", {a_oe, b_oe, c_oe}, 0);
		wb(1'b0, 8'h0C, 32'h0);
		chk("dir_pin_reset", q, 0);
		low_voltage_reset <= 1'b1;
		tick(4);
		chk("lvr_pin", {rp_oe, rp_n}, 2'b10);
		low_voltage_reset <= 1'b0;
		tick(20);
		results();
	end
endmodule
